// file: nibble_pkg.sv
// constants, command codes and bus carrier for the nibble datapath
// assumes a single 10 MHz clock that stands for the oscillator input
package nibble_pkg;

    // ----------------------------------------------------------------
    // clock derivation
    // ----------------------------------------------------------------
    localparam int unsigned CLK_RATE_HZ = 10_000_000; // oscillator rate
    localparam int unsigned SYS_DIV_SLOW = 8; // system clock divide before select
    localparam int unsigned INSTR_DIV = 4; // system ticks per machine cycle
    localparam logic [2:0] PRE_LAST = 3'(SYS_DIV_SLOW - 1);
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_COMMAND = 5'h00; // write: execute one instruction
    localparam logic [4:0] OFS_STATUS = 5'h04; // read: a, b, flags
    localparam logic [4:0] OFS_PAIR = 5'h08; // read: byte pair register
    localparam logic [4:0] OFS_POINTER = 5'h0C; // read: table pointer, rom address
    localparam logic [4:0] OFS_OPERAND = 5'h10; // read/write: ram nibble, rom word

    // command word fields
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_IMM_LSB = 8;
    // operand word fields
    localparam int unsigned OPD_RAM_LSB = 0;
    localparam int unsigned OPD_ROM_LSB = 8;
    // status word fields
    localparam int unsigned ST_A_LSB = 0;
    localparam int unsigned ST_B_LSB = 4;
    localparam int unsigned ST_CARRY = 8;
    localparam int unsigned ST_URS = 9;
    localparam int unsigned ST_FAST = 10;
    localparam int unsigned ST_EQUAL = 11;
    // pointer word fields
    localparam int unsigned PT_ROM_LSB = 8;
    // rom word bit copied into carry
    localparam int unsigned ROM_TOP_BIT = 8;

    // reset values
    localparam logic [3:0] NIBBLE_RST = 4'h0;
    localparam logic [7:0] PAIR_RST = 8'h00;
    localparam logic [2:0] POINTER_RST = 3'h0;
    localparam logic [8:0] ROM_RST = 9'h000;

    // instruction set of the datapath, codes in declaration order
    typedef enum logic [4:0] {
        OP_NOP,
        OP_LOAD_IMM,
        OP_ADD_IMM,
        OP_ADD_MEMORY,
        OP_ADD_WITH_CARRY_MEM,
        OP_COMPARE_MEM,
        OP_SET_BIT,
        OP_CLR_BIT,
        OP_ROTATE_RIGHT_INSTR,
        OP_SET_CARRY_INSTR,
        OP_CLEAR_CARRY_INSTR,
        OP_A_TO_B,
        OP_EXCHANGE_AB,
        OP_AB_TO_PAIR,
        OP_PAIR_TO_AB,
        OP_A_TO_POINTER,
        OP_TABLE_LOOKUP_INSTR,
        OP_UPPER_BIT_REF_SET_INSTR,
        OP_CLOCK_SPEED_SELECT_INSTR
    } opcode_e;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } avmm_req_s;

endpackage

// file: clock_divider.sv
// system and instruction clock strobes derived from the oscillator
// assumes i_clk is the oscillator input itself
`timescale 1ns/1ps
module clock_divider (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_fast, // clock speed select has been executed
    output logic o_sys_tick,
    output logic o_instr_tick
);
    import nibble_pkg::*;

    logic [2:0] pre_q; // oscillator prescaler
    logic [1:0] instr_q; // system ticks inside a machine cycle
    logic sys_tick_d;
    logic sys_tick_q;
    logic instr_tick_q;

    // ----------------------------------------------------------------
    // strobes
    // ----------------------------------------------------------------
    // undivided when fast, else one in eight (see RULE_01)
    assign sys_tick_d = i_fast | (pre_q == PRE_LAST);

    // counters and registered strobes, four system ticks per cycle (see RULE_02)
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_q <= 3'h0;
            instr_q <= 2'h0;
            sys_tick_q <= 1'b0;
            instr_tick_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 3'h1;
            sys_tick_q <= sys_tick_d;
            instr_tick_q <= sys_tick_d & (instr_q == INSTR_LAST);
            if (sys_tick_d) begin
                instr_q <= instr_q + 2'h1;
            end
        end
    end

    assign o_sys_tick = sys_tick_q;
    assign o_instr_tick = instr_tick_q;
endmodule

// file: nibble_adder.sv
// 4-bit adder with carry in and carry out
// assumes purely combinational use inside the datapath
`timescale 1ns/1ps
module nibble_adder (
    input wire logic [3:0] i_a,
    input wire logic [3:0] i_b,
    input wire logic i_cin,
    output logic [3:0] o_sum,
    output logic o_cout
);
    logic [4:0] total; // five-bit sum keeps the carry

    // nibble addition (see RULE_03)
    assign total = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_cin};
    assign o_sum = total[3:0];
    assign o_cout = total[4];
endmodule

// file: nibble_cpu_register_datapath.sv
// datapath of a small nibble processor: accumulator, carry, aux nibble,
// byte pair, table pointer, upper-bit reference flag and clock strobes.
// assumes an avalon-mm master that holds each request until waitrequest is low
//
// Summary of operation
// RULE_01: system clock is osc/8, then undivided
// RULE_02: instruction clock is system clock over four
// RULE_03: arithmetic unit adds, compares, manipulates 4-bit nibbles
// RULE_04: accumulator is the 4-bit working operand
// RULE_05: add-with-carry memory sets carry on overflow
// RULE_06: add immediate and add memory keep carry
// RULE_07: rotate right loads carry from accumulator bit0
// RULE_08: set carry forces 1, clear forces 0
// RULE_09: auxiliary nibble stores data, pairs with accumulator
// RULE_10: pair register: upper to aux, lower to accumulator
// RULE_11: pointer plus accumulator forms 7-bit rom address
// RULE_12: table lookup copies rom bit8 when flag set
// RULE_13: reference flag clears on reset, only settable (the code also clears it on a ram back-up return pulse)
// RULE_14: rotate right moves old carry into bit3
// RULE_15: add-with-carry sums ram, accumulator and carry
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module nibble_cpu_register_datapath (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ram_backup_return, // pulse on return from ram back-up
    input wire nibble_pkg::avmm_req_s i_avm,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic [6:0] o_rom_addr,
    output logic o_carry_flag,
    output logic o_system_clock,
    output logic o_instruction_clock
);
    import nibble_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0] acc_q; // accumulator
    logic [3:0] acc_d;
    logic [3:0] aux_q; // auxiliary nibble
    logic [3:0] aux_d;
    logic [7:0] pair_q; // byte pair register
    logic [7:0] pair_d;
    logic [2:0] ptr_q; // table pointer
    logic [2:0] ptr_d;
    logic carry_q; // carry flag
    logic carry_d;
    logic urs_q; // upper-bit reference flag
    logic urs_d;
    logic fast_q; // clock speed select has been executed
    logic fast_d;
    logic equal_q; // result of the last compare
    logic equal_d;
    logic [3:0] ram_q; // addressed ram nibble
    logic [8:0] rom_q; // rom word read at the table address
    logic rd_done_q; // read answered, waiting for release
    logic [31:0] rdata_q; // registered read data

    // ----------------------------------------------------------------
    // clock strobes
    // ----------------------------------------------------------------
    logic sys_tick;
    logic instr_tick;

    // oscillator divided into system and machine cycles
    clock_divider u_clk (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_fast(fast_q),
        .o_sys_tick(sys_tick),
        .o_instr_tick(instr_tick)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire sel_cmd = i_avm.address == OFS_COMMAND;
    wire sel_status = i_avm.address == OFS_STATUS;
    wire sel_pair = i_avm.address == OFS_PAIR;
    wire sel_ptr = i_avm.address == OFS_POINTER;
    wire sel_opd = i_avm.address == OFS_OPERAND;
    // command write waits for the next machine cycle
    wire cmd_wr = i_avm.write & sel_cmd;
    // one instruction per machine cycle (see RULE_02)
    wire exec = cmd_wr & instr_tick;
    wire opd_wr = i_avm.write & sel_opd;
    // a read takes one wait state, then stands one cycle
    wire rd_wait = i_avm.read & ~rd_done_q;

    // command fields
    wire opcode_e op = opcode_e'(i_avm.writedata[CMD_OP_LSB +: 5]);
    wire [3:0] imm = i_avm.writedata[CMD_IMM_LSB +: 4];
    wire [1:0] bit_idx = imm[1:0];

    // ----------------------------------------------------------------
    // arithmetic
    // ----------------------------------------------------------------
    logic [3:0] sum;
    logic cout;
    // immediate adds take the command nibble, others the ram nibble
    wire [3:0] add_b = (op == OP_ADD_IMM) ? imm : ram_q;
    // only add-with-carry feeds the carry in (see RULE_15)
    wire add_cin = (op == OP_ADD_WITH_CARRY_MEM) & carry_q;

    // shared adder for every add (see RULE_03)
    nibble_adder u_add (
        .i_a(acc_q),
        .i_b(add_b),
        .i_cin(add_cin),
        .o_sum(sum),
        .o_cout(cout)
    );

    // accumulator with one bit forced
    logic [3:0] bit_mask;
    assign bit_mask = 4'h1 << bit_idx;

    // rom bit reaches carry only when reference is enabled (see RULE_12)
    wire lookup_carry = urs_q ? rom_q[ROM_TOP_BIT] : carry_q;

    // ----------------------------------------------------------------
    // instruction execution
    // ----------------------------------------------------------------
    // next state of every datapath register
    always_comb begin
        acc_d = acc_q;
        aux_d = aux_q;
        pair_d = pair_q;
        ptr_d = ptr_q;
        carry_d = carry_q;
        urs_d = urs_q;
        fast_d = fast_q;
        equal_d = equal_q;
        if (exec) begin
            case (op)
                // accumulator takes the immediate (see RULE_04)
                OP_LOAD_IMM: begin
                    acc_d = imm;
                end
                // carry left alone (see RULE_06)
                OP_ADD_IMM, OP_ADD_MEMORY: begin
                    acc_d = sum;
                end
                // low nibble kept, carry out recorded (see RULE_05, RULE_15)
                OP_ADD_WITH_CARRY_MEM: begin
                    acc_d = sum;
                    carry_d = cout;
                end
                // nibble compare against ram (see RULE_03)
                OP_COMPARE_MEM: begin
                    equal_d = acc_q == ram_q;
                end
                // single-bit manipulation (see RULE_03)
                OP_SET_BIT: begin
                    acc_d = acc_q | bit_mask;
                end
                OP_CLR_BIT: begin
                    acc_d = acc_q & ~bit_mask;
                end
                // bit0 to carry (see RULE_07), old carry to bit3 (see RULE_14)
                OP_ROTATE_RIGHT_INSTR: begin
                    acc_d = {carry_q, acc_q[3:1]};
                    carry_d = acc_q[0];
                end
                // forced carry (see RULE_08)
                OP_SET_CARRY_INSTR: begin
                    carry_d = 1'b1;
                end
                OP_CLEAR_CARRY_INSTR: begin
                    carry_d = 1'b0;
                end
                // temporary nibble store (see RULE_09)
                OP_A_TO_B: begin
                    aux_d = acc_q;
                end
                OP_EXCHANGE_AB: begin
                    aux_d = acc_q;
                    acc_d = aux_q;
                end
                // byte transfer, aux high, accumulator low (see RULE_10)
                OP_AB_TO_PAIR: begin
                    pair_d = {aux_q, acc_q};
                end
                OP_PAIR_TO_AB: begin
                    aux_d = pair_q[7:4];
                    acc_d = pair_q[3:0];
                end
                // pointer loads from accumulator (see RULE_11)
                OP_A_TO_POINTER: begin
                    ptr_d = acc_q[2:0];
                end
                // rom word lands in aux and accumulator (see RULE_12)
                OP_TABLE_LOOKUP_INSTR: begin
                    aux_d = rom_q[7:4];
                    acc_d = rom_q[3:0];
                    carry_d = lookup_carry;
                end
                // set only, no instruction clears it (see RULE_13)
                OP_UPPER_BIT_REF_SET_INSTR: begin
                    urs_d = 1'b1;
                end
                // switch to the undivided system clock (see RULE_01)
                OP_CLOCK_SPEED_SELECT_INSTR: begin
                    fast_d = 1'b1;
                end
                // nop and unknown codes change nothing
                default: begin
                    acc_d = acc_q;
                end
            endcase
        end
        // back-up return clears the reference flag (see RULE_13)
        if (i_ram_backup_return) begin
            urs_d = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // datapath registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_q <= NIBBLE_RST;
            aux_q <= NIBBLE_RST;
            pair_q <= PAIR_RST;
            ptr_q <= POINTER_RST;
            carry_q <= 1'b0;
            urs_q <= 1'b0; // cleared by reset (see RULE_13)
            fast_q <= 1'b0;
            equal_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            aux_q <= aux_d;
            pair_q <= pair_d;
            ptr_q <= ptr_d;
            carry_q <= carry_d;
            urs_q <= urs_d;
            fast_q <= fast_d;
            equal_q <= equal_d;
        end
    end

    // operand register written by software
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ram_q <= NIBBLE_RST;
            rom_q <= ROM_RST;
        end else if (opd_wr) begin
            ram_q <= i_avm.writedata[OPD_RAM_LSB +: 4];
            rom_q <= i_avm.writedata[OPD_ROM_LSB +: 9];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // page-relative rom address for lookups and indirect jumps (see RULE_11)
    wire [6:0] rom_addr = {ptr_q, acc_q};

    logic [31:0] status_word;
    logic [31:0] pair_word;
    logic [31:0] ptr_word;
    logic [31:0] opd_word;
    logic [31:0] rd_mux;

    assign status_word = {20'h00000, equal_q, fast_q, urs_q, carry_q, aux_q, acc_q};
    assign pair_word = {24'h000000, pair_q};
    assign ptr_word = {17'h00000, rom_addr, 5'h00, ptr_q};
    assign opd_word = {15'h0000, rom_q, 4'h0, ram_q};

    // unmapped and write-only addresses read as zero
    assign rd_mux = sel_status ? status_word :
                    sel_pair ? pair_word :
                    sel_ptr ? ptr_word :
                    sel_opd ? opd_word : 32'h00000000;

    // read answered one cycle after it is seen
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_done_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            rd_done_q <= rd_wait;
            if (rd_wait) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // command writes stall until a machine cycle boundary
    assign o_waitrequest = rd_wait | (cmd_wr & ~instr_tick);
    assign o_readdata = rdata_q;
    assign o_rom_addr = rom_addr;
    assign o_carry_flag = carry_q;
    assign o_system_clock = sys_tick;
    assign o_instruction_clock = instr_tick;
endmodule

// file: nibble_cpu_register_datapath_properties.sv
// checker: clock strobes, bus waits, carry and accumulator
// assumes a bind to the datapath top; sees only its ports
`timescale 1ns/1ps
module nibble_datapath_checker
    import nibble_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ram_backup_return,
    input wire nibble_pkg::avmm_req_s i_avm,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic [6:0] o_rom_addr,
    input wire logic o_carry_flag,
    input wire logic o_system_clock,
    input wire logic o_instruction_clock
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic [3:0] ram_q; // ram nibble last written
    logic fast_q; // clock speed select taken
    logic fprev_q; // speed at the previous machine cycle
    logic seen_q; // one machine cycle seen
    logic sseen_q; // one system strobe seen
    logic [5:0] cyc_q; // cycles since machine cycle strobe
    logic [3:0] sgap_q; // cycles since system strobe
    logic [2:0] scnt_q; // system strobes since machine cycle strobe
    wire [4:0] op = i_avm.writedata[4:0];
    wire cmd = i_avm.write && i_avm.address == OFS_COMMAND && !o_waitrequest;
    wire [4:0] adc_sum = 5'(o_rom_addr[3:0]) + 5'(ram_q) + 5'(o_carry_flag);
    // track taken operand and speed writes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ram_q <= 4'h0;
            fast_q <= 1'b0;
        end else begin
            if (i_avm.write && i_avm.address == OFS_OPERAND && !o_waitrequest) ram_q <= i_avm.writedata[3:0];
            if (cmd && op == OP_CLOCK_SPEED_SELECT_INSTR) fast_q <= 1'b1;
        end
    end
    // strobe spacing counters
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {fprev_q, seen_q, sseen_q, cyc_q, sgap_q, scnt_q} <= '0;
        end else begin
            sgap_q <= o_system_clock ? 4'h0 : sgap_q + 4'h1;
            sseen_q <= sseen_q | o_system_clock;
            cyc_q <= o_instruction_clock ? 6'h00 : cyc_q + 6'h01;
            scnt_q <= o_instruction_clock ? 3'h0 : scnt_q + 3'(o_system_clock);
            if (o_instruction_clock) begin
                seen_q <= 1'b1;
                fprev_q <= fast_q;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_SLOW_SYS: assert property (o_system_clock && sseen_q && !fast_q |-> sgap_q == 4'h7)
        else $error("slow system strobe not every 8 cycles");
    AST_FAST_SYS: assert property (fast_q && $past(fast_q, 4) |-> o_system_clock)
        else $error("fast system strobe missing");
    AST_INSTR_PERIOD: assert property (o_instruction_clock && seen_q && fprev_q == fast_q |-> cyc_q == (fast_q ? 6'h03 : 6'h1F))
        else $error("machine cycle length wrong");
    AST_FOUR_SYS: assert property (o_instruction_clock && seen_q |-> 4'(scnt_q) + 4'(o_system_clock) == 4'h4)
        else $error("machine cycle not four system strobes");
    AST_CMD_IN_CYCLE: assert property (cmd |-> o_instruction_clock)
        else $error("command taken outside a machine cycle strobe");
    AST_CMD_WAIT: assert property (i_avm.write && i_avm.address == OFS_COMMAND |-> ##[0:31] !o_waitrequest)
        else $error("command wait too long");
    AST_ROT_CARRY: assert property (cmd && op == OP_ROTATE_RIGHT_INSTR |=> o_carry_flag == $past(o_rom_addr[0]))
        else $error("rotate did not load carry from bit0");
    AST_ROT_ACC: assert property (cmd && op == OP_ROTATE_RIGHT_INSTR |=> o_rom_addr[3:0] == {$past(o_carry_flag), $past(o_rom_addr[3:1])})
        else $error("rotate result wrong");
    AST_CARRY_FORCE: assert property (cmd && op inside {OP_SET_CARRY_INSTR, OP_CLEAR_CARRY_INSTR} |=> o_carry_flag == ($past(op) == OP_SET_CARRY_INSTR))
        else $error("set or clear carry wrong");
    AST_ADD_KEEP: assert property (cmd && op inside {OP_ADD_IMM, OP_ADD_MEMORY} |=> $stable(o_carry_flag))
        else $error("plain add changed carry");
    AST_ADC: assert property (cmd && op == OP_ADD_WITH_CARRY_MEM |=> {o_carry_flag, o_rom_addr[3:0]} == $past(adc_sum))
        else $error("add with carry result wrong");
    AST_POINTER: assert property (cmd && op == OP_A_TO_POINTER |=> o_rom_addr[6:4] == $past(o_rom_addr[2:0]))
        else $error("pointer load wrong");
    AST_IDLE_HOLD: assert property (!cmd |=> $stable(o_rom_addr) && $stable(o_carry_flag))
        else $error("state changed without a command");
    // scenarios
    COV_LOOKUP: cover property (cmd && op == OP_TABLE_LOOKUP_INSTR);
    COV_FAST: cover property ($rose(fast_q));
    COV_ADC_CARRY: cover property (cmd && op == OP_ADD_WITH_CARRY_MEM && adc_sum[4]);
endmodule
bind nibble_cpu_register_datapath nibble_datapath_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_ram_backup_return(i_ram_backup_return), .i_avm(i_avm), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_rom_addr(o_rom_addr), .o_carry_flag(o_carry_flag),
    .o_system_clock(o_system_clock), .o_instruction_clock(o_instruction_clock));

// file: nibble_cpu_register_datapath_tb.sv
// self-checking bench, random commands against a model
// assumes the package, datapath and checker are compiled first
`timescale 1ns/1ps
module nibble_cpu_register_datapath_tb;
    import nibble_pkg::*;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    typedef struct packed {logic eq; logic f; logic u; logic c; logic [3:0] b; logic [3:0] a; logic [7:0] e; logic [2:0] d;} model_s;
    logic i_clk, i_resetn, i_ram_backup_return;
    avmm_req_s avm;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [6:0] o_rom_addr;
    logic o_carry_flag, o_system_clock, o_instruction_clock;
    int errors, tests_run;
    logic [31:0] seed;
    logic [31:0] rd, r;
    model_s m; // expected datapath state
    logic [3:0] ram; // ram nibble last written
    logic [8:0] rom; // rom word last written
    nibble_cpu_register_datapath DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_ram_backup_return(i_ram_backup_return),
        .i_avm(avm), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_rom_addr(o_rom_addr),
        .o_carry_flag(o_carry_flag), .o_system_clock(o_system_clock), .o_instruction_clock(o_instruction_clock));
    // 10 MHz oscillator
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // ----------------------------------------------------------------
    // expectation functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // next state for one instruction; unknown codes are nops
    function automatic model_s step(model_s s, logic [4:0] op, logic [3:0] k);
        case (op)
            OP_LOAD_IMM: s.a = k;
            OP_ADD_IMM: s.a = s.a + k;
            OP_ADD_MEMORY: s.a = s.a + ram;
            OP_ADD_WITH_CARRY_MEM: {s.c, s.a} = 5'(s.a) + 5'(ram) + 5'(s.c);
            OP_COMPARE_MEM: s.eq = (s.a == ram);
            OP_SET_BIT: s.a[k[1:0]] = 1'b1;
            OP_CLR_BIT: s.a[k[1:0]] = 1'b0;
            OP_ROTATE_RIGHT_INSTR: {s.a, s.c} = {s.c, s.a};
            OP_SET_CARRY_INSTR: s.c = 1'b1;
            OP_CLEAR_CARRY_INSTR: s.c = 1'b0;
            OP_A_TO_B: s.b = s.a;
            OP_EXCHANGE_AB: {s.a, s.b} = {s.b, s.a};
            OP_AB_TO_PAIR: s.e = {s.b, s.a};
            OP_PAIR_TO_AB: {s.b, s.a} = s.e;
            OP_A_TO_POINTER: s.d = s.a[2:0];
            OP_TABLE_LOOKUP_INSTR: begin
                {s.b, s.a} = rom[7:0];
                if (s.u) s.c = rom[8];
            end
            OP_UPPER_BIT_REF_SET_INSTR: s.u = 1'b1;
            OP_CLOCK_SPEED_SELECT_INSTR: s.f = 1'b1;
            default: ;
        endcase
        return s;
    endfunction
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd, output logic [31:0] q);
        int n;
        @(posedge i_clk);
        avm <= '{!wr, wr, adr, wd};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 100);
        q = o_readdata;
        avm.read <= 1'b0;
        avm.write <= 1'b0;
        if (n >= 100) begin
            errors++;
            stop_test();
        end
    endtask
    // read back registers and ports against the model
    task automatic check_state();
        logic [31:0] x;
        bus(1'b0, OFS_STATUS, 32'h0, x);
        chk(x, {20'h0, m.eq, m.f, m.u, m.c, m.b, m.a});
        bus(1'b0, OFS_PAIR, 32'h0, x);
        chk(x, {24'h0, m.e});
        bus(1'b0, OFS_POINTER, 32'h0, x);
        chk(x, {17'h0, m.d, m.a, 5'h0, m.d});
        chk(32'({o_carry_flag, o_rom_addr}), 32'({m.c, m.d, m.a}));
    endtask
    task automatic exec(input logic [4:0] op, input logic [3:0] k);
        bus(1'b1, OFS_COMMAND, {20'h0, k, 3'h0, op}, rd);
        m = step(m, op, k);
        check_state();
    endtask
    task automatic operand(input logic [3:0] n, input logic [8:0] w);
        bus(1'b1, OFS_OPERAND, {15'h0, w, 4'h0, n}, rd);
        ram = n;
        rom = w;
    endtask
    // cycles between two strobes of the chosen kind
    task automatic period(input logic sel, input int exp);
        int n;
        n = 0;
        while ((sel ? o_instruction_clock : o_system_clock) !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while ((sel ? o_instruction_clock : o_system_clock) !== 1'b1 && n < 100);
        chk(32'(n), 32'(exp));
        if (n >= 100) stop_test();
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h7EF9FFC1;
        {errors, tests_run} = '0;
        {m, ram, rom} = '0;
        i_resetn = 1'b0;
        i_ram_backup_return = 1'b0;
        avm = '0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        check_state();
        bus(1'b0, 5'h14, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, OFS_STATUS, 32'h00000FFF, rd);
        check_state();
        period(1'b0, 8);
        period(1'b1, 32);
        operand(4'hF, 9'h1A5);
        exec(OP_LOAD_IMM, 4'h1);
        exec(OP_ADD_WITH_CARRY_MEM, 4'h0);
        exec(OP_ADD_IMM, 4'hF);
        exec(OP_ADD_MEMORY, 4'h0);
        exec(OP_ROTATE_RIGHT_INSTR, 4'h0);
        exec(OP_SET_CARRY_INSTR, 4'h0);
        exec(OP_CLEAR_CARRY_INSTR, 4'h0);
        exec(OP_TABLE_LOOKUP_INSTR, 4'h0);
        exec(OP_UPPER_BIT_REF_SET_INSTR, 4'h0);
        exec(OP_TABLE_LOOKUP_INSTR, 4'h0);
        @(posedge i_clk);
        i_ram_backup_return <= 1'b1;
        @(posedge i_clk);
        i_ram_backup_return <= 1'b0;
        m.u = 1'b0;
        check_state();
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            if (r[31:30] == 2'h0) operand(r[3:0], r[24:16]);
            exec(r[8:4], r[12:9]);
        end
        exec(OP_CLOCK_SPEED_SELECT_INSTR, 4'h0);
        period(1'b0, 1);
        period(1'b1, 4);
        stop_test();
    end
endmodule
